// ---- hw/power_state_pkg.sv ----
// constants and types for the power state and reset controller
// Summary of operation
// [R1] power button falling edge is one event
// [R2] button event wakes from sleep or powers down
// [R3] low reset button requests module reboot
// [R4] reset button taken on its falling edge
// [R5] carrier drops power-good when reset fails
// [R6] any reset cause drives carrier reset low
// [R7] carrier reset is active low output
// [R8] power-good high means supplies in range
// [R9] startup held off while power-good low
// [R10] suspend warning asserted before low power
// [R11] suspend-to-ram low while in S3
// [R12] suspend-to-disk low while in S4
// [R13] soft-off indication asserted while in S5
// [R14] expansion wake low wakes the system
// [R15] general wake low wakes the system
// [R16] battery low forces orderly power saving
// [R17] lid switch level reported to software
// [R18] sleep button level reported to software
// [R19] watchdog expiry output, also resets carrier
// [R20] all carrier inputs pass two synchroniser flops; the watchdog and software inputs do not
// [R21] carrier reset low at least one cycle
package power_state_pkg;
  // number of carrier inputs passed through the synchroniser
  localparam int unsigned SYNC_WIDTH = 9;
  // bit positions inside the synchronised input vector
  localparam int unsigned IN_PWR_BTN = 0;
  localparam int unsigned IN_RST_BTN = 1;
  localparam int unsigned IN_PWR_OK  = 2;
  localparam int unsigned IN_EXPANSION_WAKE_N   = 3;
  localparam int unsigned IN_GENERAL_WAKE_N   = 4;
  localparam int unsigned IN_BATTERY_LOW_N  = 5;
  localparam int unsigned IN_LID     = 6;
  localparam int unsigned IN_SLEEP   = 7;
  localparam int unsigned IN_12V_OK  = 8;
  // idle value of the synchroniser: buttons high, power not yet good
  localparam logic [8:0] SYNC_RESET = 9'h1fb;
  // warning lead time before entering a low power state, in ns
  localparam int unsigned WARN_LEAD_NS = 16;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam logic [3:0] WARN_CYCLES = 4'((WARN_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // extra low cycles of carrier reset after the last cause clears
  localparam logic [3:0] RESET_MIN_CYCLES = 4'h2;
  // power states of the system
  typedef enum logic [2:0] {
    ST_S5,
    ST_S4,
    ST_S3,
    ST_S0,
    ST_WARN
  } power_state_e;
  // requested sleep depth from software
  localparam logic [1:0] REQ_S3 = 2'h0;
  localparam logic [1:0] REQ_S4 = 2'h1;
  localparam logic [1:0] REQ_S5 = 2'h2;
endpackage : power_state_pkg

// ---- hw/input_sync.sv ----
// two-flop synchroniser for the carrier board inputs
`timescale 1ns/10ps
module input_sync
  import power_state_pkg::*;
(
  input  wire logic                  sys_clk_i,   // system clock
  input  wire logic                  reset_i,     // async reset, active high
  input  wire logic [SYNC_WIDTH-1:0] async_i,     // raw carrier inputs
  output logic      [SYNC_WIDTH-1:0] sync_o       // synchronised copy
);
  // register pair, meta stage read only by the second stage
  typedef struct packed {
    logic [SYNC_WIDTH-1:0] meta;
    logic [SYNC_WIDTH-1:0] stable;
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  // next state: shift one stage per clock
  always_comb begin
    state_d        = state_q;
    state_d.meta   = async_i;        // see [R20]
    state_d.stable = state_q.meta;   // see [R20]
  end

  // state register, idle levels under reset
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= {SYNC_RESET, SYNC_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stable;
endmodule : input_sync

// ---- hw/power_state_reset_control.sv ----
// power state sequencer and carrier reset generator
`timescale 1ns/10ps
module power_state_reset_control
  import power_state_pkg::*;
(
  input  wire logic       sys_clk_i,           // 250 MHz system clock
  input  wire logic       reset_i,             // async reset, active high
  input  wire logic       power_button_n_i,    // power button, low active
  input  wire logic       reset_button_n_i,    // reset button, low active
  input  wire logic       power_good_i,        // supply good, high active
  input  wire logic       main_supply_ok_i,    // 12 V input above minimum
  input  wire logic       expansion_wake_n_i,  // expansion bus wake, low active
  input  wire logic       general_wake_n_i,    // general wake, low active
  input  wire logic       battery_low_n_i,     // battery low, low active
  input  wire logic       lid_switch_n_i,      // lid switch, low active
  input  wire logic       sleep_button_n_i,    // sleep button, low active
  input  wire logic       watchdog_expired_i,  // watchdog timeout pulse/level
  input  wire logic       sw_reset_req_i,      // software reset request pulse
  input  wire logic       sw_sleep_req_i,      // software sleep request pulse
  input  wire logic [1:0] sw_sleep_depth_i,    // depth for the sleep request
  output logic            carrier_reset_n_o,   // carrier board reset, low active
  output logic            suspend_warning_n_o, // imminent suspend, low active
  output logic            suspend_to_ram_n_o,  // low while in S3
  output logic            suspend_to_disk_n_o, // low while in S4
  output logic            soft_off_n_o,        // low while in S5
  output logic            watchdog_event_o,    // watchdog timeout seen
  output logic            lid_closed_o,        // lid closed, to software
  output logic            sleep_pressed_o,     // sleep button held, to software
  output logic            power_event_o,       // one-cycle power button event
  output logic            wake_event_o,        // one-cycle wake event
  output logic            module_reset_o       // module reboot request, high
);

  // synchronised inputs
  logic [SYNC_WIDTH-1:0] raw_in;
  logic [SYNC_WIDTH-1:0] sync_in;

  assign raw_in = {main_supply_ok_i, sleep_button_n_i, lid_switch_n_i, battery_low_n_i,
                   general_wake_n_i, expansion_wake_n_i, power_good_i, reset_button_n_i,
                   power_button_n_i};

  // every carrier input crosses two flops first
  input_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (raw_in),     // see [R20]
    .sync_o    (sync_in)
  );

  // all state of the sequencer
  typedef struct packed {
    power_state_e state;      // current power state
    logic [1:0]   depth;      // target of the pending sleep
    logic [3:0]   warn_cnt;   // warning lead counter
    logic [3:0]   rst_cnt;    // carrier reset stretch counter
    logic         pwr_prev;   // last power button level
    logic         rst_prev;   // last reset button level
    logic         carrier_n;  // carrier reset output
    logic         wdt_flag;   // watchdog event output
    logic         pwr_evt;    // power button event pulse
    logic         wake_evt;   // wake event pulse
    logic         mod_rst;    // module reboot pulse
    logic         lid;        // lid closed output
    logic         slp;        // sleep button output
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  // decoded conditions
  logic pwr_fall;    // power button falling edge
  logic rst_fall;    // reset button falling edge
  logic wake_any;    // any wake source active
  logic rst_cause;   // any reset cause active
  logic batt_low;    // battery low level
  logic asleep;      // in S3, S4 or S5

  assign pwr_fall  = q.pwr_prev && !sync_in[IN_PWR_BTN];  // see [R1]
  assign rst_fall  = q.rst_prev && !sync_in[IN_RST_BTN];  // see [R4]
  assign wake_any  = pwr_fall || !sync_in[IN_EXPANSION_WAKE_N] || !sync_in[IN_GENERAL_WAKE_N];  // see [R14] see [R15]
  assign batt_low  = !sync_in[IN_BATTERY_LOW_N];
  // any sleep state, used by the checks below
  assign asleep    = (q.state == ST_S3) || (q.state == ST_S4) || (q.state == ST_S5);
  // low button level, power not good, 12 V low, watchdog or software
  assign rst_cause = !sync_in[IN_RST_BTN] || !sync_in[IN_PWR_OK] || !sync_in[IN_12V_OK] ||
                     watchdog_expired_i || sw_reset_req_i;  // see [R6] see [R8]

  // next-state logic
  always_comb begin
    d          = q;
    d.pwr_prev = sync_in[IN_PWR_BTN];
    d.rst_prev = sync_in[IN_RST_BTN];
    d.pwr_evt  = pwr_fall;                            // see [R1]
    d.wake_evt = 1'b0;
    d.mod_rst  = rst_fall;                            // see [R3] see [R4]
    d.lid      = !sync_in[IN_LID];                    // see [R17]
    d.slp      = !sync_in[IN_SLEEP];                  // see [R18]
    // watchdog flag sticks until the carrier reset stretch ends
    if (watchdog_expired_i) begin
      d.wdt_flag = 1'b1;                              // see [R19]
    end else if (!rst_cause && q.rst_cnt == 4'h0) begin
      d.wdt_flag = 1'b0;
    end
    // stretch keeps a one-cycle cause visible for a full cycle or more
    if (rst_cause) begin
      d.rst_cnt   = RESET_MIN_CYCLES;                 // see [R21]
      d.carrier_n = 1'b0;                             // see [R6] see [R7]
    end else if (q.rst_cnt != 4'h0) begin
      d.rst_cnt   = q.rst_cnt - 4'h1;
      d.carrier_n = 1'b0;                             // see [R21]
    end else begin
      d.carrier_n = 1'b1;
    end
    // power state machine
    case (q.state)
      ST_S5, ST_S4, ST_S3: begin
        // startup waits for good power; otherwise a wake resumes
        if (wake_any && sync_in[IN_PWR_OK] && !batt_low) begin  // see [R2] see [R9]
          d.state    = ST_S0;
          d.wake_evt = 1'b1;
        end
      end
      ST_S0: begin
        // battery low and button both shut down to soft off
        if (batt_low || pwr_fall) begin               // see [R2] see [R16]
          d.state    = ST_WARN;
          d.depth    = REQ_S5;
          d.warn_cnt = WARN_CYCLES;
        end else if (sw_sleep_req_i) begin
          d.state    = ST_WARN;
          d.depth    = sw_sleep_depth_i;
          d.warn_cnt = WARN_CYCLES;
        end
      end
      ST_WARN: begin
        // warning holds for the lead time, then the rail state moves
        if (q.warn_cnt != 4'h0) begin
          d.warn_cnt = q.warn_cnt - 4'h1;             // see [R10]
        end else if (q.depth == REQ_S3) begin
          d.state = ST_S3;
        end else if (q.depth == REQ_S4) begin
          d.state = ST_S4;
        end else begin
          d.state = ST_S5;
        end
      end
      default: begin
        d.state = ST_S5;
      end
    endcase
  end

  // state register; system starts in soft off with carrier held in reset
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q           <= '0;
      q.state     <= ST_S5;
      q.pwr_prev  <= 1'b1;
      q.rst_prev  <= 1'b1;
      q.rst_cnt   <= RESET_MIN_CYCLES;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops or state decode
  assign carrier_reset_n_o   = q.carrier_n;                    // see [R7]
  assign suspend_warning_n_o = (q.state != ST_WARN);           // see [R10]
  assign suspend_to_ram_n_o  = !(q.state == ST_S3 || q.state == ST_S4 || q.state == ST_S5);  // see [R11]
  assign suspend_to_disk_n_o = !(q.state == ST_S4 || q.state == ST_S5);  // see [R12]
  assign soft_off_n_o        = (q.state != ST_S5);             // see [R13]
  assign watchdog_event_o    = q.wdt_flag;                     // see [R19]
  assign lid_closed_o        = q.lid;
  assign sleep_pressed_o     = q.slp;
  assign power_event_o       = q.pwr_evt;
  assign wake_event_o        = q.wake_evt;
  assign module_reset_o      = q.mod_rst;

  // reset cause must pull the carrier reset low next cycle
  carrier_reset_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R6]
    rst_cause |=> !carrier_reset_n_o) else $error("carrier reset not driven low");
  // low for at least two cycles after any cause
  reset_stretch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R21]
    $rose(rst_cause) |=> !carrier_reset_n_o [*2]) else $error("carrier reset too short");
  // warning leads every sleep entry
  warn_lead_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R10]
    (q.state == ST_S0 && d.state == ST_WARN) |=> !suspend_warning_n_o [*5])
    else $error("suspend warning lead too short");
  // no wake without good power
  startup_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R9]
    (q.state == ST_S5 && !sync_in[IN_PWR_OK]) |=> q.state != ST_S0) else $error("started without power good");
  // power button edge gives one event pulse
  button_event_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R1]
    pwr_fall |=> power_event_o ##1 !power_event_o) else $error("power button event wrong");
  // in S3 the S3 line is low and the S4 line stays high
  ram_state_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R11]
    (q.state == ST_S3) |-> !suspend_to_ram_n_o && suspend_to_disk_n_o) else $error("S3 indication wrong");
  // soft off indication tied to S5
  soft_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R13]
    (q.state == ST_S5) == !soft_off_n_o) else $error("soft off indication wrong");
  // battery low in run leaves for soft off
  battery_low_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R16]
    (q.state == ST_S0 && batt_low) |=> q.state == ST_WARN ##5 q.state == ST_S5)
    else $error("battery low did not power down");
  // watchdog shows on its output next cycle
  watchdog_flag_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R19]
    watchdog_expired_i |=> watchdog_event_o && !carrier_reset_n_o) else $error("watchdog not reported");

  // deeper sleep keeps the shallower lines low too
  disk_state_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R12]
    (q.state == ST_S4) |-> !suspend_to_disk_n_o && !suspend_to_ram_n_o && soft_off_n_o)
    else $error("S4 indication wrong");

  // running shows no sleep line and no warning
  run_lines_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R11]
    (q.state == ST_S0) |-> suspend_to_ram_n_o && suspend_to_disk_n_o && soft_off_n_o && suspend_warning_n_o)
    else $error("run indication wrong");

  // a sleep line only falls right after the warning
  sleep_entry_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R10]
    $fell(suspend_to_ram_n_o) |-> !$past(suspend_warning_n_o))
    else $error("sleep entered without warning");

  // warning done, shallow request lands in S3
  ram_entry_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R11]
    (q.state == ST_WARN && q.warn_cnt == 4'h0 && q.depth == REQ_S3) |=> q.state == ST_S3)
    else $error("S3 not entered");

  // warning done, disk request lands in S4
  disk_entry_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R12]
    (q.state == ST_WARN && q.warn_cnt == 4'h0 && q.depth == REQ_S4) |=> q.state == ST_S4)
    else $error("S4 not entered");

  // every other depth code ends in soft off
  off_entry_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R13]
    (q.state == ST_WARN && q.warn_cnt == 4'h0 && q.depth != REQ_S3 && q.depth != REQ_S4)
    |=> q.state == ST_S5) else $error("S5 not entered");

  // reset button edge gives one reboot pulse
  reboot_pulse_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R3]
    rst_fall |=> module_reset_o ##1 !module_reset_o)
    else $error("reboot pulse wrong");

  // reboot pulse always comes with the carrier in reset
  reboot_reset_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R3]
    module_reset_o |-> !carrier_reset_n_o)
    else $error("reboot without carrier reset");

  // a held button gives no second reboot pulse
  held_button_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R4]
    (!sync_in[IN_RST_BTN] && !q.rst_prev) |=> !module_reset_o)
    else $error("reboot repeated on level");

  // button press wakes a sleeping system
  button_wake_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R2]
    (asleep && pwr_fall && sync_in[IN_PWR_OK] && !batt_low) |=> q.state == ST_S0 && wake_event_o)
    else $error("button did not wake");

  // button press while running heads for soft off
  button_off_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R2]
    (q.state == ST_S0 && pwr_fall) |=> q.state == ST_WARN && q.depth == REQ_S5)
    else $error("button did not power down");

  // expansion bus wake resumes from any sleep
  expansion_wake_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R14]
    (asleep && !sync_in[IN_EXPANSION_WAKE_N] && sync_in[IN_PWR_OK] && !batt_low) |=> q.state == ST_S0 && wake_event_o)
    else $error("expansion wake ignored");

  // general wake resumes from any sleep
  general_wake_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R15]
    (asleep && !sync_in[IN_GENERAL_WAKE_N] && sync_in[IN_PWR_OK] && !batt_low) |=> q.state == ST_S0 && wake_event_o)
    else $error("general wake ignored");

  // low battery keeps a sleeping system down
  battery_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R16]
    (asleep && batt_low) |=> q.state != ST_S0)
    else $error("woke on low battery");

  // no wake pulse while the supply is not good
  power_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R9]
    (asleep && !sync_in[IN_PWR_OK]) |=> !wake_event_o)
    else $error("wake without power good");

  // software sleep only taken while running
  sleep_ignored_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R10]
    (asleep && sw_sleep_req_i) |=> q.state != ST_WARN)
    else $error("sleep request taken while asleep");

  // lid output follows the pin one cycle later
  lid_report_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R17]
    lid_closed_o != $past(sync_in[IN_LID]))
    else $error("lid report wrong");

  // sleep button output follows the pin one cycle later
  sleep_report_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R18]
    sleep_pressed_o != $past(sync_in[IN_SLEEP]))
    else $error("sleep button report wrong");

  // two flops between pin and logic, once out of reset
  sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R20]
    (!$past(reset_i) && !$past(reset_i, 2)) |-> sync_in == $past(raw_in, 2))
    else $error("synchroniser depth wrong");

  // watchdog flag drops once every cause and stretch is over
  watchdog_clear_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R19]
    (!watchdog_expired_i && !rst_cause && q.rst_cnt == 4'h0) |=> !watchdog_event_o)
    else $error("watchdog flag stuck");

  // carrier released only after a cycle with no cause
  reset_release_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R7]
    carrier_reset_n_o |-> !$past(rst_cause))
    else $error("carrier released under a cause");

  // bad supply always holds the carrier in reset
  supply_reset_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // see [R8]
    !sync_in[IN_PWR_OK] |=> !carrier_reset_n_o)
    else $error("carrier not reset on bad supply");
endmodule : power_state_reset_control

// ---- testbench/carrier_model.sv ----
// carrier board model: buttons, wakes, switches and supply status
`timescale 1ns/10ps
module carrier_model (
  input  wire logic [8:0] cause_i, // set bit means condition active
  output logic      [8:0] pins_o   // pin levels seen by the module
);
  // lines in the mask idle high on pull-ups and go low when active
  localparam logic [8:0] ACTIVE_LOW_MASK = 9'h0fb;
  // one clean step per change, no bounce; supply good only when in range
  always_comb begin
    pins_o = cause_i ^ ACTIVE_LOW_MASK;
  end
endmodule : carrier_model

// ---- testbench/power_state_reset_control_bench.sv ----
// self-checking bench for the power state and reset controller
`timescale 1ns/10ps
module power_state_reset_control_bench;
  import power_state_pkg::*;
  logic       sys_clk_i, reset_i, watchdog_expired_i, sw_reset_req_i, sw_sleep_req_i;
  logic [1:0] sw_sleep_depth_i;  // sleep depth code
  logic [8:0] cause_q;           // carrier conditions, set bit = active
  logic [8:0] pins;              // carrier pin levels
  logic       carrier_reset_n_o, suspend_warning_n_o, suspend_to_ram_n_o, suspend_to_disk_n_o;
  logic       soft_off_n_o, watchdog_event_o, lid_closed_o, sleep_pressed_o;
  logic       power_event_o, wake_event_o, module_reset_o;
  int         n_mismatch, total_checks, n_pwr, n_wake, n_mrst;
  carrier_model u_carrier_model (.cause_i(cause_q), .pins_o(pins));
  power_state_reset_control u_power_state_reset_control (
    .sys_clk_i, .reset_i, .power_button_n_i(pins[IN_PWR_BTN]), .reset_button_n_i(pins[IN_RST_BTN]),
    .power_good_i(pins[IN_PWR_OK]), .main_supply_ok_i(pins[IN_12V_OK]),
    .expansion_wake_n_i(pins[IN_EXPANSION_WAKE_N]), .general_wake_n_i(pins[IN_GENERAL_WAKE_N]),
    .battery_low_n_i(pins[IN_BATTERY_LOW_N]), .lid_switch_n_i(pins[IN_LID]), .sleep_button_n_i(pins[IN_SLEEP]),
    .watchdog_expired_i, .sw_reset_req_i, .sw_sleep_req_i, .sw_sleep_depth_i, .carrier_reset_n_o,
    .suspend_warning_n_o, .suspend_to_ram_n_o, .suspend_to_disk_n_o, .soft_off_n_o, .watchdog_event_o,
    .lid_closed_o, .sleep_pressed_o, .power_event_o, .wake_event_o, .module_reset_o);
  // clock, 4 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // pulse counters, so one-cycle pulses are never missed
  always @(posedge sys_clk_i) begin
    if (power_event_o === 1'b1) n_pwr++;
    if (wake_event_o === 1'b1) n_wake++;
    if (module_reset_o === 1'b1) n_mrst++;
  end
  // let n edges pass, then step just off the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // warning, ram, disk and soft-off lines as one nibble
  function automatic logic [3:0] lines();
    return {suspend_warning_n_o, suspend_to_ram_n_o, suspend_to_disk_n_o, soft_off_n_o};
  endfunction : lines
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  // startup held off until power good, then soft-off
  task automatic t_startup();
    int w0;
    w0 = n_wake;
    step(8);
    check("reset while supply bad", 8'(carrier_reset_n_o), 8'h0);
    // a press before power good must not start the system
    cause_q[IN_PWR_BTN] = 1'b1;
    step(6);
    cause_q[IN_PWR_BTN] = 1'b0;
    step(6);
    check("no startup without supply", 8'(lines()), 8'h8);
    check("no wake without supply", 8'(n_wake - w0), 8'h0);
    cause_q[IN_PWR_OK] = 1'b1;
    step(12);
    check("reset after supply good", 8'(carrier_reset_n_o), 8'h1);
    check("soft-off lines", 8'(lines()), 8'h8);
    $display("test startup done");
  endtask : t_startup
  // one press is one event; wakes from sleep or powers down from S0
  task automatic t_press(input logic [3:0] exp);
    int p0;
    p0 = n_pwr;
    cause_q[IN_PWR_BTN] = 1'b1;
    step(12);
    cause_q[IN_PWR_BTN] = 1'b0;
    step(12);
    check("button events", 8'(n_pwr - p0), 8'h1);
    check("lines after press", 8'(lines()), 8'(exp));
    $display("test press done");
  endtask : t_press
  // sleep at a depth with warning first, then wake through one input
  task automatic t_sleep(input logic [1:0] depth, input logic [3:0] exp, input int wbit);
    int w0;
    w0 = n_wake;
    sw_sleep_depth_i = depth;
    sw_sleep_req_i = 1'b1;
    step(1);
    sw_sleep_req_i = 1'b0;
    step(2);
    check("warning before sleep", 8'(suspend_warning_n_o), 8'h0);
    step(10);
    check("sleep lines", 8'(lines()), 8'(exp));
    cause_q[wbit] = 1'b1;
    step(8);
    cause_q[wbit] = 1'b0;
    step(6);
    check("lines after wake", 8'(lines()), 8'hf);
    check("wake events", 8'(n_wake - w0), 8'h1);
    $display("test sleep done");
  endtask : t_sleep
  // battery low from running goes to soft-off
  task automatic t_battery();
    cause_q[IN_BATTERY_LOW_N] = 1'b1;
    step(14);
    check("lines on battery low", 8'(lines()), 8'h8);
    cause_q[IN_BATTERY_LOW_N] = 1'b0;
    step(4);
    $display("test battery done");
  endtask : t_battery
  // lid and sleep button levels reported
  task automatic t_report();
    cause_q[IN_LID] = 1'b1;
    cause_q[IN_SLEEP] = 1'b1;
    step(6);
    check("lid and sleep held", 8'({lid_closed_o, sleep_pressed_o}), 8'h3);
    cause_q[IN_LID] = 1'b0;
    step(6);
    check("lid open, sleep held", 8'({lid_closed_o, sleep_pressed_o}), 8'h1);
    cause_q[IN_SLEEP] = 1'b0;
    step(6);
    check("both released", 8'({lid_closed_o, sleep_pressed_o}), 8'h0);
    $display("test report done");
  endtask : t_report
  // turn one reset cause on or off
  task automatic apply_cause(input int k, input logic v);
    case (k)
      0: cause_q[IN_RST_BTN] = v;
      1: cause_q[IN_PWR_OK] = !v;
      2: cause_q[IN_12V_OK] = !v;
      3: watchdog_expired_i = v;
      default: sw_reset_req_i = v;
    endcase
  endtask : apply_cause
  // every cause pulls carrier reset low; a one-cycle cause still gives a full low cycle
  task automatic t_resets();
    int m0, lows;
    for (int k = 0; k < 5; k++) begin
      m0 = n_mrst;
      apply_cause(k, 1'b1);
      step(6);
      check("carrier reset on cause", 8'(carrier_reset_n_o), 8'h0);
      if (k == 3) check("watchdog flag", 8'(watchdog_event_o), 8'h1);
      apply_cause(k, 1'b0);
      step(10);
      check("carrier reset released", 8'(carrier_reset_n_o), 8'h1);
      if (k == 3) check("watchdog flag cleared", 8'(watchdog_event_o), 8'h0);
      if (k == 0) check("reboot requests", 8'(n_mrst - m0), 8'h1);
    end
    lows = 0;
    apply_cause(4, 1'b1);
    step(1);
    apply_cause(4, 1'b0);
    for (int i = 0; i < 8; i++) begin
      if (carrier_reset_n_o === 1'b0) lows++;
      step(1);
    end
    // one cycle for the cause itself plus the stretch
    check("short cause low time", 8'(lows), 8'(1 + RESET_MIN_CYCLES));
    $display("test resets done");
  endtask : t_resets
  initial begin
    {n_mismatch, total_checks, n_pwr, n_wake, n_mrst} = '0;
    {watchdog_expired_i, sw_reset_req_i, sw_sleep_req_i, sw_sleep_depth_i} = '0;
    cause_q = 9'h100;
    reset_i = 1'b1;
    step(10);
    reset_i = 1'b0;
    t_startup();
    t_press(4'hf);
    t_sleep(2'h0, 4'hb, IN_EXPANSION_WAKE_N);
    t_sleep(2'h1, 4'h9, IN_GENERAL_WAKE_N);
    t_sleep(2'h2, 4'h8, IN_PWR_BTN);
    t_press(4'h8);
    t_press(4'hf);
    t_battery();
    t_report();
    t_resets();
    summarize();
  end
  // watchdog on the whole run, far beyond the expected length
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_mismatch++;
    summarize();
  end
endmodule : power_state_reset_control_bench
